// ===== logic/cal_seq_pkg.sv
// constants shared by the calibration sequencer and its host controller
// ==========================================
// Summary of operation
// - mode code 1,1,1 starts system full-scale calibration
// - host holds full-scale input steady throughout
// - calibration uses gain from range bits
// - ac or dc excitation per ac bit
// - 22 periods chopped, 24 unchopped
// - mode bits cleared to 0,0,0 at end
// - ready high during calibration, low after
// - only selected channel gain coefficient updated
// - host writes continuous or single to convert
// - ready may lag one modulator cycle; ignored
// - zero-scale calibration precedes full-scale one
// - later full-scale calibrations adjust gain only
// - full-scale point at most 1.05 nominal range
// - span between 0.8 and 2.1 nominal
// - reset loads defaults and nominal coefficients
// - host calibrates after power-up, reference settled
// - host waits oscillator start-up before calibrating
// - all rates derived from master clock
// - master clock presented on output pin
// - mode code 1,1,0 starts system zero-scale
// - mode code 1,0,1 starts internal full-scale
package cal_seq_pkg;
  localparam logic [2:0] MODE_IDLE = 3'h0;
  localparam logic [2:0] MODE_CONT = 3'h1;
  localparam logic [2:0] MODE_SINGLE = 3'h2;
  localparam logic [2:0] MODE_STANDBY = 3'h3;
  localparam logic [2:0] MODE_INT_ZS = 3'h4;
  localparam logic [2:0] MODE_INT_FS = 3'h5;
  localparam logic [2:0] MODE_SYS_ZS = 3'h6;
  localparam logic [2:0] MODE_SYS_FS = 3'h7;
  // periods of the output rate per calibration
  localparam int CAL_PERIODS_CHOP = 22;
  localparam int CAL_PERIODS_NOCHOP = 24;
  localparam int INT_FS_PERIODS_CHOP = 44;
  localparam int INT_FS_PERIODS_NOCHOP = 48;
  // master clock cycles per modulator cycle
  localparam int MOD_DIV = 32;
  // default output period in modulator cycles
  localparam int OUT_PERIOD_MOD = 4;
  localparam int COEF_W = 24;
  localparam logic [23:0] OFFSET_NOMINAL = 24'h800000;
  localparam logic [23:0] GAIN_NOMINAL = 24'h59AEE7;
  // oscillator start-up wait, in us
  localparam int OSC_STARTUP_US = 6000;
  localparam int CLK_MHZ = 25;
  localparam int OSC_STARTUP_CYC = OSC_STARTUP_US * CLK_MHZ;
endpackage : cal_seq_pkg

// ===== logic/cal_link_if.sv
// mode, setup and ready wires between host and converter
`timescale 1ns/1ps
`default_nettype none
interface cal_link_if;
  logic mode_wr;
  logic op_mode_bit2;
  logic op_mode_bit1;
  logic op_mode_bit0;
  logic input_range_bit1;
  logic input_range_bit0;
  logic chop_enable;
  logic ac_excitation_enable;
  logic channel_sel;
  logic rdy_n;
  logic [2:0] mode_rb;
  logic mclk_out;
  modport dev (
    input mode_wr, op_mode_bit2, op_mode_bit1, op_mode_bit0, input_range_bit1, input_range_bit0,
    input chop_enable, ac_excitation_enable, channel_sel,
    output rdy_n, mode_rb, mclk_out
  );
  modport host (
    output mode_wr, op_mode_bit2, op_mode_bit1, op_mode_bit0, input_range_bit1, input_range_bit0,
    output chop_enable, ac_excitation_enable, channel_sel,
    input rdy_n, mode_rb, mclk_out
  );
endinterface : cal_link_if
`default_nettype wire

// ===== logic/cal_device.sv
// converter end: calibration sequencer with coefficient store
`timescale 1ns/1ps
`default_nettype none
module cal_device
  import cal_seq_pkg::*;
#(
  parameter int OUT_PERIOD = OUT_PERIOD_MOD,
  parameter int CHANNELS = 2
) (
  input wire logic clock,
  input wire logic srst,
  cal_link_if.dev link,
  input wire logic [COEF_W-1:0] cal_result,
  output logic cal_busy,
  output logic [1:0] pga_gain_sel,
  output logic excitation_ac,
  output logic ac_excite_clk,
  output logic [COEF_W-1:0] gain_coef_0,
  output logic [COEF_W-1:0] offset_coef_0,
  output logic [COEF_W-1:0] gain_coef_1,
  output logic [COEF_W-1:0] offset_coef_1
);
  typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_RUN} state_e;
  // ==========================================
  // timebase
  // modulator and output ticks from the master clock so all scale with it
  logic [4:0] mod_cnt_r, mod_cnt_nxt;
  logic [7:0] out_cnt_r, out_cnt_nxt;
  logic mod_tick, out_tick;
  assign mod_tick = (mod_cnt_r == 5'(MOD_DIV - 1));
  assign out_tick = mod_tick && (out_cnt_r == 8'(OUT_PERIOD - 1));
  always_comb begin
    mod_cnt_nxt = mod_tick ? 5'h00 : mod_cnt_r + 5'h01;
    out_cnt_nxt = out_cnt_r;
    if (mod_tick) begin
      out_cnt_nxt = out_tick ? 8'h00 : out_cnt_r + 8'h01;
    end
  end
  always_ff @(posedge clock) begin
    if (srst) begin
      mod_cnt_r <= 5'h00;
      out_cnt_r <= 8'h00;
    end else begin
      mod_cnt_r <= mod_cnt_nxt;
      out_cnt_r <= out_cnt_nxt;
    end
  end
  // ==========================================
  // sequencer
  state_e st_r, st_nxt;
  logic [2:0] mode_r, mode_nxt;
  logic [5:0] per_r, per_nxt;
  logic rdy_n_r, rdy_n_nxt;
  logic chan_r, chan_nxt;
  logic [COEF_W-1:0] gain_r [CHANNELS], gain_nxt [CHANNELS];
  logic [COEF_W-1:0] offs_r [CHANNELS], offs_nxt [CHANNELS];
  logic [2:0] wr_code;
  logic is_cal;
  logic [5:0] periods;
  assign wr_code = {link.op_mode_bit2, link.op_mode_bit1, link.op_mode_bit0};
  assign is_cal = (wr_code == MODE_SYS_FS) || (wr_code == MODE_SYS_ZS)
               || (wr_code == MODE_INT_FS) || (wr_code == MODE_INT_ZS);
  // internal full-scale takes two steps, hence double length
  always_comb begin
    if (mode_r == MODE_INT_FS) begin
      periods = link.chop_enable ? 6'(INT_FS_PERIODS_CHOP) : 6'(INT_FS_PERIODS_NOCHOP);
    end else begin
      periods = link.chop_enable ? 6'(CAL_PERIODS_CHOP) : 6'(CAL_PERIODS_NOCHOP);
    end
  end
  always_comb begin
    st_nxt = st_r;
    mode_nxt = mode_r;
    per_nxt = per_r;
    rdy_n_nxt = rdy_n_r;
    chan_nxt = chan_r;
    for (int i = 0; i < CHANNELS; i++) begin
      gain_nxt[i] = gain_r[i];
      offs_nxt[i] = offs_r[i];
    end
    case (st_r)
      ST_IDLE: begin
        if (link.mode_wr) begin
          mode_nxt = wr_code;
          chan_nxt = link.channel_sel;
          // a calibration waits for a modulator boundary; ready may lag
          if (is_cal) begin
            st_nxt = ST_WAIT;
          end
        end
      end
      ST_WAIT: begin
        if (mod_tick) begin
          st_nxt = ST_RUN;
          rdy_n_nxt = 1'b1;
          per_nxt = 6'h00;
        end
      end
      ST_RUN: begin
        if (out_tick) begin
          per_nxt = per_r + 6'h01;
          if (per_r + 6'h01 == periods) begin
            st_nxt = ST_IDLE;
            rdy_n_nxt = 1'b0;
            mode_nxt = MODE_IDLE;
            // only the chosen channel's coefficient changes; no data result
            if (mode_r == MODE_SYS_FS || mode_r == MODE_INT_FS) begin
              gain_nxt[chan_r] = cal_result;
            end else begin
              offs_nxt[chan_r] = cal_result;
            end
          end
        end
      end
      default: st_nxt = ST_IDLE;
    endcase
  end
  always_ff @(posedge clock) begin
    if (srst) begin
      st_r <= ST_IDLE;
      mode_r <= MODE_IDLE;
      per_r <= 6'h00;
      rdy_n_r <= 1'b1;
      chan_r <= 1'b0;
      for (int i = 0; i < CHANNELS; i++) begin
        gain_r[i] <= GAIN_NOMINAL;
        offs_r[i] <= OFFSET_NOMINAL;
      end
    end else begin
      st_r <= st_nxt;
      mode_r <= mode_nxt;
      per_r <= per_nxt;
      rdy_n_r <= rdy_n_nxt;
      chan_r <= chan_nxt;
      for (int i = 0; i < CHANNELS; i++) begin
        gain_r[i] <= gain_nxt[i];
        offs_r[i] <= offs_nxt[i];
      end
    end
  end
  // ==========================================
  // front-end steering and outputs
  logic ac_r, ac_nxt;
  logic [1:0] gain_sel_r, gain_sel_nxt;
  always_comb begin
    gain_sel_nxt = {link.input_range_bit1, link.input_range_bit0};
    // internal full-scale always runs dc
    ac_nxt = link.ac_excitation_enable && (mode_r != MODE_INT_FS);
  end
  always_ff @(posedge clock) begin
    if (srst) begin
      ac_r <= 1'b0;
      gain_sel_r <= 2'h0;
    end else begin
      ac_r <= ac_nxt;
      gain_sel_r <= gain_sel_nxt;
    end
  end
  assign link.rdy_n = rdy_n_r;
  assign link.mode_rb = mode_r;
  assign link.mclk_out = clock;
  assign cal_busy = (st_r == ST_RUN);
  assign pga_gain_sel = gain_sel_r;
  assign excitation_ac = ac_r;
  // excitation flips once per modulator cycle while ac is on, when OUT_PERIOD is even
  assign ac_excite_clk = ac_r & out_cnt_r[0];
  assign gain_coef_0 = gain_r[0];
  assign offset_coef_0 = offs_r[0];
  assign gain_coef_1 = gain_r[CHANNELS-1];
  assign offset_coef_1 = offs_r[CHANNELS-1];
endmodule : cal_device
`default_nettype wire

// ===== logic/cal_host.sv
// host end: orders zero-scale then full-scale calibration, then converts
`timescale 1ns/1ps
`default_nettype none
module cal_host
  import cal_seq_pkg::*;
#(
  parameter int STARTUP_CYC = OSC_STARTUP_CYC,
  parameter int IGNORE_CYC = MOD_DIV
) (
  input wire logic clock,
  input wire logic srst,
  cal_link_if.host link,
  input wire logic start,
  input wire logic gain_only,
  input wire logic single_shot,
  input wire logic [1:0] range_sel,
  input wire logic chop_sel,
  input wire logic ac_sel,
  input wire logic chan_sel,
  output logic busy,
  output logic done
);
  typedef enum logic [2:0] {H_BOOT, H_IDLE, H_ZS, H_FS, H_CONV, H_DONE} hstate_e;
  hstate_e st_r, st_nxt;
  logic [31:0] cnt_r, cnt_nxt;
  logic issued_r, issued_nxt;
  logic full_done_r, full_done_nxt;
  logic wr;
  logic [2:0] code;
  // ==========================================
  // sequence
  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    issued_nxt = issued_r;
    full_done_nxt = full_done_r;
    wr = 1'b0;
    code = MODE_IDLE;
    case (st_r)
      H_BOOT: begin
        // oscillator and reference must settle before calibrating
        cnt_nxt = cnt_r + 32'h1;
        if (cnt_r >= 32'(STARTUP_CYC)) begin
          st_nxt = H_IDLE;
        end
      end
      H_IDLE: begin
        if (start) begin
          cnt_nxt = 32'h0;
          issued_nxt = 1'b0;
          st_nxt = (gain_only && full_done_r) ? H_FS : H_ZS;
        end
      end
      H_ZS, H_FS: begin
        if (!issued_r) begin
          wr = 1'b1;
          code = (st_r == H_ZS) ? MODE_SYS_ZS : MODE_SYS_FS;
          issued_nxt = 1'b1;
          cnt_nxt = 32'h0;
        end else begin
          // ready is untrustworthy for a modulator cycle after the write
          if (cnt_r < 32'(IGNORE_CYC) + 32'h2) begin
            cnt_nxt = cnt_r + 32'h1;
          end else if (!link.rdy_n) begin
            issued_nxt = 1'b0;
            st_nxt = (st_r == H_ZS) ? H_FS : H_CONV;
            if (st_r == H_FS) begin
              full_done_nxt = 1'b1;
            end
          end
        end
      end
      H_CONV: begin
        wr = 1'b1;
        code = single_shot ? MODE_SINGLE : MODE_CONT;
        st_nxt = H_DONE;
      end
      H_DONE: st_nxt = H_IDLE;
      default: st_nxt = H_IDLE;
    endcase
  end
  always_ff @(posedge clock) begin
    if (srst) begin
      st_r <= H_BOOT;
      cnt_r <= 32'h0;
      issued_r <= 1'b0;
      full_done_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      issued_r <= issued_nxt;
      full_done_r <= full_done_nxt;
    end
  end
  // span and full-scale level are analog choices made outside this logic
  assign link.mode_wr = wr;
  assign link.op_mode_bit2 = code[2];
  assign link.op_mode_bit1 = code[1];
  assign link.op_mode_bit0 = code[0];
  assign link.input_range_bit1 = range_sel[1];
  assign link.input_range_bit0 = range_sel[0];
  assign link.chop_enable = chop_sel;
  assign link.ac_excitation_enable = ac_sel;
  assign link.channel_sel = chan_sel;
  assign busy = (st_r != H_IDLE);
  assign done = (st_r == H_DONE);
endmodule : cal_host
`default_nettype wire

// ===== tb/cal_link_monitor.sv
// concurrent checks on the host-converter calibration link
`timescale 1ns/1ps
`default_nettype none
module cal_link_monitor
  import cal_seq_pkg::*;
#(
  parameter int OUT_PERIOD = 1
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic mode_wr,
  input wire logic op_mode_bit2,
  input wire logic op_mode_bit1,
  input wire logic op_mode_bit0,
  input wire logic chop_enable,
  input wire logic rdy_n,
  input wire logic [2:0] mode_rb
);
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  // ==========================================
  // helper state
  logic [2:0] code;
  logic cal_on;
  logic take;
  logic [11:0] len_r;
  logic [11:0] len_nxt;
  logic zs_r;
  logic zs_nxt;
  int per;
  assign code = {op_mode_bit2, op_mode_bit1, op_mode_bit0};
  assign cal_on = rdy_n && (mode_rb == MODE_SYS_FS || mode_rb == MODE_SYS_ZS);
  assign take = mode_wr && !cal_on;
  assign per = (chop_enable ? CAL_PERIODS_CHOP : CAL_PERIODS_NOCHOP) * MOD_DIV * OUT_PERIOD;
  // length restarts at each accepted write, so idle time is never counted
  always_comb begin
    len_nxt = len_r;
    zs_nxt = zs_r | (mode_rb == MODE_SYS_ZS && rdy_n);
    if (take) begin
      len_nxt = 12'h001;
    end else if (rdy_n) begin
      len_nxt = len_r + 12'h001;
    end
  end
  // register helper state
  always_ff @(posedge clock) begin
    if (srst) begin
      len_r <= 12'h000;
      zs_r <= 1'b0;
    end else begin
      len_r <= len_nxt;
      zs_r <= zs_nxt;
    end
  end
  // ==========================================
  // assertions
  AST_FS_TAKE: assert property (take && code == MODE_SYS_FS |=> mode_rb == MODE_SYS_FS)
    else $error("full-scale code not taken");
  AST_ZS_TAKE: assert property (take && code == MODE_SYS_ZS |=> mode_rb == MODE_SYS_ZS)
    else $error("zero-scale code not taken");
  AST_RDY_LAG: assert property (take && code[2:1] == 2'h3 |-> ##[1:34] rdy_n)
    else $error("ready not raised within a modulator cycle");
  AST_HOLD: assert property (cal_on |=> (rdy_n && mode_rb == $past(mode_rb)) || (!rdy_n && mode_rb == MODE_IDLE))
    else $error("mode not held or not cleared at end");
  AST_CAL_LEN: assert property (cal_on ##1 !rdy_n |-> len_r >= per - 1 && len_r <= per + 40)
    else $error("calibration length wrong");
  AST_NO_WR_BUSY: assert property (cal_on |-> !mode_wr)
    else $error("mode written during calibration");
  AST_ZS_FIRST: assert property (mode_wr && code == MODE_SYS_FS |-> zs_r)
    else $error("full-scale issued before zero-scale");
  AST_LOW_STAND: assert property (!rdy_n && !mode_wr && mode_rb == MODE_IDLE |=> !rdy_n)
    else $error("ready rose without a command");
  // main scenarios reached
  cover property (take && code == MODE_SYS_FS);
  cover property (take && code == MODE_SYS_ZS);
  cover property (cal_on && !chop_enable ##1 !rdy_n);
endmodule : cal_link_monitor
`default_nettype wire

// ===== tb/system_gain_calibration_sequencer_tb.sv
// self-checking bench: host and converter joined over the calibration link
`timescale 1ns/1ps
`default_nettype none
module system_gain_calibration_sequencer_tb;
  import cal_seq_pkg::*;
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic start = 1'b0;
  logic gain_only = 1'b0;
  logic single_shot = 1'b0;
  logic [1:0] range_sel = 2'h0;
  logic chop_sel = 1'b1;
  logic ac_sel = 1'b0;
  logic chan_sel = 1'b0;
  logic [23:0] cal_result = 24'h000000;
  logic cal_busy, excitation_ac, busy, done;
  logic [1:0] pga_gain_sel;
  logic [23:0] g0, o0, g1, o1;
  logic [23:0] mg [2];
  logic [23:0] mo [2];
  logic [95:0] exp_q [$];
  int err_total = 0;
  int total_checks = 0;
  int seed = 32'h6b01ea76;
  int n;
  // 25 MHz
  always #20 clock = ~clock;
  // ==========================================
  // both ends and the link checker
  cal_link_if cal_link_if_inst ();
  cal_device #(.OUT_PERIOD(1), .CHANNELS(2)) cal_device_inst (.clock(clock), .srst(srst),
    .link(cal_link_if_inst), .cal_result(cal_result), .cal_busy(cal_busy), .pga_gain_sel(pga_gain_sel),
    .excitation_ac(excitation_ac), .ac_excite_clk(), .gain_coef_0(g0), .offset_coef_0(o0),
    .gain_coef_1(g1), .offset_coef_1(o1));
  cal_host #(.STARTUP_CYC(10), .IGNORE_CYC(MOD_DIV)) cal_host_inst (.clock(clock), .srst(srst),
    .link(cal_link_if_inst), .start(start), .gain_only(gain_only), .single_shot(single_shot),
    .range_sel(range_sel), .chop_sel(chop_sel), .ac_sel(ac_sel), .chan_sel(chan_sel), .busy(busy), .done(done));
  cal_link_monitor #(.OUT_PERIOD(1)) cal_link_monitor_inst (.clock(clock), .srst(srst),
    .mode_wr(cal_link_if_inst.mode_wr), .op_mode_bit2(cal_link_if_inst.op_mode_bit2),
    .op_mode_bit1(cal_link_if_inst.op_mode_bit1), .op_mode_bit0(cal_link_if_inst.op_mode_bit0),
    .chop_enable(cal_link_if_inst.chop_enable), .rdy_n(cal_link_if_inst.rdy_n), .mode_rb(cal_link_if_inst.mode_rb));
  // ==========================================
  // checking and closing
  task automatic chk(input logic [95:0] seen, input logic [95:0] want);
    total_checks++;
    if (seen !== want) begin
      err_total++;
      $display("unexpected at %0t: got %h want %h", $time, seen, want);
    end
  endtask : chk
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : conclude
  // one edge of a bounded wait; a hang counts as a mismatch
  task automatic wait_edge();
    @(posedge clock);
    #1;
    if (n > 4000) begin
      err_total++;
      $display("unexpected at %0t: wait ran out", $time);
      conclude();
    end
  endtask : wait_edge
  // coefficient bank compared against the oldest note on each finish
  // falling edge: done and the bank are settled, no race with the launching edge
  always @(negedge clock) begin
    if (done === 1'b1) begin
      if (exp_q.size() == 0) chk(96'h1, 96'h0);
      else chk({g0, o0, g1, o1}, exp_q.pop_front());
    end
  end
  // ==========================================
  // one host sequence; gain-only runs must leave offsets alone
  task automatic run(input logic go, input logic ch);
    logic [23:0] v;
    v = 24'($random(seed));
    range_sel = 2'($random(seed));
    ac_sel = 1'($random(seed));
    single_shot = 1'($random(seed));
    chan_sel = 1'($random(seed));
    chop_sel = ch;
    gain_only = go;
    cal_result = v;
    mg[chan_sel] = v;
    if (!go) mo[chan_sel] = v;
    exp_q.push_back({mg[0], mo[0], mg[1], mo[1]});
    for (n = 0; busy !== 1'b0; n++) wait_edge();
    start = 1'b1;
    @(posedge clock);
    #1 start = 1'b0;
    for (n = 0; cal_busy !== 1'b1; n++) wait_edge();
    wait_edge();
    chk(pga_gain_sel, range_sel);
    chk(excitation_ac, ac_sel);
    for (n = 0; done !== 1'b1; n++) wait_edge();
    wait_edge();
    chk(cal_link_if_inst.mode_rb, single_shot ? MODE_SINGLE : MODE_CONT);
    $display("test end: chop %0d gain only %0d", ch, go);
  endtask : run
  // main sequence; gain-only alternates and chop runs 1,0,0,1 so both lengths are seen
  initial begin
    mg[0] = GAIN_NOMINAL;
    mg[1] = GAIN_NOMINAL;
    mo[0] = OFFSET_NOMINAL;
    mo[1] = OFFSET_NOMINAL;
    repeat (20) @(posedge clock);
    #1 srst = 1'b0;
    chk({g0, o0, g1, o1}, {GAIN_NOMINAL, OFFSET_NOMINAL, GAIN_NOMINAL, OFFSET_NOMINAL});
    chk({cal_link_if_inst.rdy_n, cal_link_if_inst.mode_rb}, {1'b1, MODE_IDLE});
    chk(cal_link_if_inst.mclk_out, clock);
    for (int i = 0; i < 4; i++) begin
      run(i[0], ~(i[0] ^ i[1]));
    end
    repeat (4) @(posedge clock);
    chk(exp_q.size(), 0);
    conclude();
  end
endmodule : system_gain_calibration_sequencer_tb
`default_nettype wire
